// ==== hw/ccs_clock_switch.sv ====
// Purpose: Selects the CPU clock source and sequences switches and standby.
// Assumes: Gate outputs drive an external glitch-free clock mux cell.
// Notes: Oscillator ready levels arrive from the analog side, asynchronously.
`timescale 1ns/1ps
module ccs_clock_switch
    import ccs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic main_osc_ready,
    input wire logic internal_osc_ready,
    input wire logic halt_exec,
    input wire logic stop_exec,
    input wire logic wake_event,
    output ccs_osc_cfg_t osc_cfg,
    output logic main_osc_enable,
    output logic internal_osc_enable,
    output logic gate_internal,
    output logic gate_external,
    output logic main_clock_status,
    output logic cpu_clock_run,
    output logic halt_mode,
    output logic stop_mode
);

    // ================================================================
    // Oscillator status synchronisers
    logic stabilization_time_status, internal_osc_stable;

    ccs_sync3 u_sync_main (.clk(clk), .reset(reset), .async_in(main_osc_ready),
        .sync_out(stabilization_time_status));
    ccs_sync3 u_sync_int (.clk(clk), .reset(reset), .async_in(internal_osc_ready),
        .sync_out(internal_osc_stable));

    // ================================================================
    // Write decode
    logic wr_osc, wr_moc, wr_mcm, wr_rcm;

    assign wr_osc = reg_wr && (reg_addr == CCS_ADDR_OSC_MODE);
    assign wr_moc = reg_wr && (reg_addr == CCS_ADDR_MAIN_OSC_CTL);
    assign wr_mcm = reg_wr && (reg_addr == CCS_ADDR_MAIN_CLK_MODE);
    assign wr_rcm = reg_wr && (reg_addr == CCS_ADDR_INT_OSC_MODE);

    // ================================================================
    // Change-once bits: amplifier gain and source select
    logic amp_gain, amp_locked, system_clock_source_select, src_locked;

    ccs_once_bit u_once_gain (.clk(clk), .reset(reset), .wr_en(wr_osc),
        .wr_bit(reg_wdata[CCS_BIT_AMP_GAIN]), .value(amp_gain), .locked(amp_locked));
    ccs_once_bit u_once_src (.clk(clk), .reset(reset), .wr_en(wr_mcm),
        .wr_bit(reg_wdata[CCS_BIT_SRC_SEL]), .value(system_clock_source_select),
        .locked(src_locked));

    // ================================================================
    // Software control bits
    logic external_clock_input_sel, oscillator_mode_select, main_oscillator_stop;
    logic main_clock_select, internal_osc_stop;
    logic next_ext_sel, next_osc_sel, next_main_stop, next_clk_sel, next_int_stop;

    always_comb begin
        next_ext_sel = external_clock_input_sel;
        next_osc_sel = oscillator_mode_select;
        next_main_stop = main_oscillator_stop;
        next_clk_sel = main_clock_select;
        next_int_stop = internal_osc_stop;
        if (wr_osc) begin
            next_ext_sel = reg_wdata[CCS_BIT_EXT_CLK];
            next_osc_sel = reg_wdata[CCS_BIT_OSC_SEL];
        end
        if (wr_moc) begin
            next_main_stop = reg_wdata[CCS_BIT_MAIN_STOP];
        end
        if (wr_mcm) begin
            next_clk_sel = reg_wdata[CCS_BIT_CLK_SEL];
        end
        if (wr_rcm) begin
            next_int_stop = reg_wdata[CCS_BIT_INT_STOP];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            external_clock_input_sel <= 1'b0;
            oscillator_mode_select <= 1'b0;
            main_oscillator_stop <= CCS_RST_MAIN_STOP;
            main_clock_select <= 1'b0;
            internal_osc_stop <= CCS_RST_INT_STOP;
        end else begin
            external_clock_input_sel <= next_ext_sel;
            oscillator_mode_select <= next_osc_sel;
            main_oscillator_stop <= next_main_stop;
            main_clock_select <= next_clk_sel;
            internal_osc_stop <= next_int_stop;
        end
    end

    // ================================================================
    // Standby mode
    ccs_mode_t mode, next_mode;

    always_comb begin
        next_mode = mode;
        case (mode)
            CCS_MODE_RUN: begin
                if (stop_exec) begin
                    next_mode = CCS_MODE_STOP;
                end else if (halt_exec) begin
                    next_mode = CCS_MODE_HALT;
                end
            end
            CCS_MODE_HALT,
            CCS_MODE_STOP: begin
                if (wake_event) begin
                    next_mode = CCS_MODE_RUN;
                end
            end
            default: begin
                next_mode = CCS_MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode <= CCS_MODE_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // ================================================================
    // Source switch sequencer
    // Switches start only while running, but a gap already begun runs to its end,
    // so a standby state keeps the source in use when it was entered unless entered mid-gap.
    ccs_src_state_t src_state, next_src_state;
    logic [CCS_CNT_W-1:0] gap_cnt, next_gap_cnt;
    logic ext_ok, int_ok;

    // The external source must be selected, running and, for a crystal, settled.
    assign ext_ok = main_clock_select && system_clock_source_select
        && oscillator_mode_select && !main_oscillator_stop
        && (external_clock_input_sel || stabilization_time_status);
    assign int_ok = !main_clock_select && !internal_osc_stop
        && internal_osc_stable;

    always_comb begin
        next_src_state = src_state;
        next_gap_cnt = gap_cnt;
        case (src_state)
            CCS_SRC_INT: begin
                if (mode == CCS_MODE_RUN && ext_ok) begin
                    next_src_state = CCS_SRC_GAP_TO_EXT;
                    next_gap_cnt = CCS_CNT_W'(CCS_SWITCH_GAP_CYCLES - 1);
                end
            end
            CCS_SRC_GAP_TO_EXT: begin
                if (gap_cnt == '0) begin
                    next_src_state = CCS_SRC_EXT;
                end else begin
                    next_gap_cnt = gap_cnt - 1'b1;
                end
            end
            CCS_SRC_EXT: begin
                if (mode == CCS_MODE_RUN && int_ok) begin
                    next_src_state = CCS_SRC_GAP_TO_INT;
                    next_gap_cnt = CCS_CNT_W'(CCS_SWITCH_GAP_CYCLES - 1);
                end
            end
            CCS_SRC_GAP_TO_INT: begin
                if (gap_cnt == '0) begin
                    next_src_state = CCS_SRC_INT;
                end else begin
                    next_gap_cnt = gap_cnt - 1'b1;
                end
            end
            default: begin
                next_src_state = CCS_SRC_INT;
                next_gap_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            src_state <= CCS_SRC_INT;
            gap_cnt <= '0;
        end else begin
            src_state <= next_src_state;
            gap_cnt <= next_gap_cnt;
        end
    end

    // ================================================================
    // Registered outputs
    ccs_osc_cfg_t next_osc_cfg;
    logic next_main_en, next_int_en, next_gate_int, next_gate_ext, next_status;

    always_comb begin
        next_osc_cfg.external_clock_input_sel = external_clock_input_sel;
        next_osc_cfg.oscillator_mode_select = oscillator_mode_select;
        next_osc_cfg.amplifier_gain_high = amp_gain;
        next_main_en = !main_oscillator_stop && (mode != CCS_MODE_STOP);
        next_int_en = !internal_osc_stop && (mode != CCS_MODE_STOP);
        // Both gates are low through the gap, so no runt pulse reaches the CPU.
        next_gate_int = (next_src_state == CCS_SRC_INT);
        next_gate_ext = (next_src_state == CCS_SRC_EXT);
        next_status = main_clock_status;
        if (next_src_state == CCS_SRC_EXT) begin
            next_status = 1'b1;
        end else if (next_src_state == CCS_SRC_INT) begin
            next_status = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_cfg <= '0;
            main_osc_enable <= 1'b0;
            internal_osc_enable <= 1'b1;
            gate_internal <= 1'b1;
            gate_external <= 1'b0;
            main_clock_status <= 1'b0;
            cpu_clock_run <= 1'b1;
            halt_mode <= 1'b0;
            stop_mode <= 1'b0;
        end else begin
            osc_cfg <= next_osc_cfg;
            main_osc_enable <= next_main_en;
            internal_osc_enable <= next_int_en;
            gate_internal <= next_gate_int;
            gate_external <= next_gate_ext;
            main_clock_status <= next_status;
            cpu_clock_run <= (next_mode == CCS_MODE_RUN);
            halt_mode <= (next_mode == CCS_MODE_HALT);
            stop_mode <= (next_mode == CCS_MODE_STOP);
        end
    end

    // ================================================================
    // Read port
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = CCS_READ_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                CCS_ADDR_OSC_MODE: begin
                    next_rdata[CCS_BIT_EXT_CLK] = external_clock_input_sel;
                    next_rdata[CCS_BIT_OSC_SEL] = oscillator_mode_select;
                    next_rdata[CCS_BIT_AMP_GAIN] = amp_gain;
                end
                CCS_ADDR_MAIN_OSC_CTL: begin
                    next_rdata[CCS_BIT_MAIN_STOP] = main_oscillator_stop;
                end
                CCS_ADDR_MAIN_CLK_MODE: begin
                    next_rdata[CCS_BIT_SRC_SEL] = system_clock_source_select;
                    next_rdata[CCS_BIT_CLK_STATUS] = main_clock_status;
                    next_rdata[CCS_BIT_CLK_SEL] = main_clock_select;
                end
                CCS_ADDR_INT_OSC_MODE: begin
                    next_rdata[CCS_BIT_INT_STABLE] = internal_osc_stable;
                    next_rdata[CCS_BIT_INT_STOP] = internal_osc_stop;
                end
                CCS_ADDR_STAB_STATUS: begin
                    next_rdata[CCS_BIT_STAB_DONE] = stabilization_time_status;
                end
                default: begin
                    next_rdata = CCS_READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= CCS_READ_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ================================================================
    // Assertions
    a_reset_internal_src: assert property (@(posedge clk)
        $fell(reset) |-> gate_internal && !gate_external && !main_clock_status)
        else $error("CPU not on internal oscillator after reset");
    a_gates_never_both: assert property (@(posedge clk) disable iff (reset)
        !(gate_internal && gate_external))
        else $error("Both clock gates open at once");
    a_ext_switch_gap: assert property (@(posedge clk) disable iff (reset)
        $fell(gate_internal) && src_state == CCS_SRC_GAP_TO_EXT
        |-> !gate_external [*2] ##1 (gate_external && main_clock_status))
        else $error("Switch to external did not follow the gap");
    a_ext_needs_setup: assert property (@(posedge clk) disable iff (reset)
        $rose(gate_external) |-> osc_cfg.oscillator_mode_select
        && !main_oscillator_stop && system_clock_source_select)
        else $error("External gate opened without oscillator setup");
    a_select_bit_write: assert property (@(posedge clk) disable iff (reset)
        wr_mcm |=> main_clock_select == $past(reg_wdata[CCS_BIT_CLK_SEL]))
        else $error("Main clock select not written");
    a_stop_bit_write: assert property (@(posedge clk) disable iff (reset)
        wr_moc |=> main_oscillator_stop == $past(reg_wdata[CCS_BIT_MAIN_STOP]))
        else $error("Main oscillator stop not written");
    a_int_stop_gates: assert property (@(posedge clk) disable iff (reset)
        internal_osc_stop |=> !internal_osc_enable)
        else $error("Internal oscillator enabled while stopped");
    a_src_sel_once: assert property (@(posedge clk) disable iff (reset)
        src_locked && wr_mcm |=> $stable(system_clock_source_select))
        else $error("Source select changed twice");
    a_gain_once: assert property (@(posedge clk) disable iff (reset)
        amp_locked && wr_osc |=> $stable(amp_gain))
        else $error("Amplifier gain changed twice");
    a_int_return_stable: assert property (@(posedge clk) disable iff (reset)
        $rose(gate_internal) |-> $past(internal_osc_stable, 3))
        else $error("Returned to internal oscillator while not stable");
    a_halt_keeps_src: assert property (@(posedge clk) disable iff (reset)
        halt_mode && $past(halt_mode) |-> $stable(main_clock_status))
        else $error("Clock source changed during HALT");
    a_status_readback: assert property (@(posedge clk) disable iff (reset)
        reg_rd && reg_addr == CCS_ADDR_MAIN_CLK_MODE
        |=> reg_rdata[CCS_BIT_CLK_STATUS] == $past(main_clock_status))
        else $error("Status bit read back wrong");

endmodule

// ==== hw/ccs_once_bit.sv ====
// Purpose: Control bit that may change value only once after reset.
// Assumes: Write enable is a one-cycle strobe.
// Notes: Writing the value already held does not use up the change.
`timescale 1ns/1ps
module ccs_once_bit (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic wr_bit,
    output logic value,
    output logic locked
);
    logic next_value;
    logic next_locked;

    always_comb begin
        next_value = value;
        next_locked = locked;
        if (wr_en && !locked && (wr_bit != value)) begin
            next_value = wr_bit;
            next_locked = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            value <= 1'b0;
            locked <= 1'b0;
        end else begin
            value <= next_value;
            locked <= next_locked;
        end
    end
endmodule

// ==== hw/ccs_pkg.sv ====
// Purpose: Shared constants and types for the CPU clock source switch.
// Assumes: One 10 MHz clock; registers reached over a plain strobe port.
// Notes: Register indices are byte addresses on the 8-bit register port.
package ccs_pkg;

    // ================================================================
    // Register map
    localparam logic [7:0] CCS_ADDR_OSC_MODE = 8'h00;
    localparam logic [7:0] CCS_ADDR_MAIN_OSC_CTL = 8'h01;
    localparam logic [7:0] CCS_ADDR_MAIN_CLK_MODE = 8'h02;
    localparam logic [7:0] CCS_ADDR_INT_OSC_MODE = 8'h03;
    localparam logic [7:0] CCS_ADDR_STAB_STATUS = 8'h04;

    // ================================================================
    // Field positions
    localparam int CCS_BIT_EXT_CLK = 7;
    localparam int CCS_BIT_OSC_SEL = 6;
    localparam int CCS_BIT_AMP_GAIN = 0;
    localparam int CCS_BIT_MAIN_STOP = 7;
    localparam int CCS_BIT_SRC_SEL = 2;
    localparam int CCS_BIT_CLK_STATUS = 1;
    localparam int CCS_BIT_CLK_SEL = 0;
    localparam int CCS_BIT_INT_STABLE = 7;
    localparam int CCS_BIT_INT_STOP = 0;
    localparam int CCS_BIT_STAB_DONE = 0;

    // ================================================================
    // Reset values
    localparam logic CCS_RST_MAIN_STOP = 1'b1;
    localparam logic CCS_RST_INT_STOP = 1'b0;
    localparam logic [7:0] CCS_READ_ZERO = 8'h00;

    // ================================================================
    // Timing: both gates stay off this long during a source change
    localparam int CCS_CLK_PERIOD_NS = 100;
    localparam int CCS_SWITCH_GAP_NS = 200;
    localparam int CCS_SWITCH_GAP_CYCLES =
        (CCS_SWITCH_GAP_NS + CCS_CLK_PERIOD_NS - 1) / CCS_CLK_PERIOD_NS;
    localparam int CCS_CNT_W = 4;

    // ================================================================
    // Types
    typedef struct packed {
        logic external_clock_input_sel;
        logic oscillator_mode_select;
        logic amplifier_gain_high;
    } ccs_osc_cfg_t;

    typedef enum logic [2:0] {
        CCS_SRC_INT = 3'b000,
        CCS_SRC_GAP_TO_EXT = 3'b001,
        CCS_SRC_EXT = 3'b010,
        CCS_SRC_GAP_TO_INT = 3'b011
    } ccs_src_state_t;

    typedef enum logic [1:0] {
        CCS_MODE_RUN = 2'b00,
        CCS_MODE_HALT = 2'b01,
        CCS_MODE_STOP = 2'b10
    } ccs_mode_t;

endpackage

// ==== hw/ccs_sync3.sv ====
// Purpose: Three-stage synchroniser for one asynchronous level.
// Assumes: Input comes from outside the clk domain.
// Notes: The output follows once the second and third stages agree.
`timescale 1ns/1ps
module ccs_sync3 (
    input wire logic clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_sync_out;

    always_comb begin
        next_stage = {stage[1:0], async_in};
        next_sync_out = sync_out;
        if (stage[1] == stage[2]) begin
            next_sync_out = stage[2];
        end
    end

    // The first stage is read only by the second, to keep metastability contained.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage <= 3'h0;
            sync_out <= 1'b0;
        end else begin
            stage <= next_stage;
            sync_out <= next_sync_out;
        end
    end
endmodule

// ==== tb/ccs_clock_switch_tb.sv ====
// Purpose: Self-checking bench for the CPU clock source switch.
// Assumes: Register port reads answer in the cycle after the strobe.
// Notes: Reads queue their expected value; a watcher compares them.
`timescale 1ns/1ps
module ccs_clock_switch_tb;
    import ccs_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic main_osc_ready;
    logic internal_osc_ready;
    logic halt_exec = 1'b0;
    logic stop_exec = 1'b0;
    logic wake_event = 1'b0;
    ccs_osc_cfg_t osc_cfg;
    logic main_osc_enable;
    logic internal_osc_enable;
    logic gate_internal;
    logic gate_external;
    logic main_clock_status;
    logic cpu_clock_run;
    logic halt_mode;
    logic stop_mode;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] ra;
    int seed = 32'hc1fe;
    int n_errors = 0;
    int n_tests = 0;
    wire logic [3:0] watch = {internal_osc_ready, main_osc_ready, gate_external, gate_internal};
    wire logic [7:0] clk_view = {4'h0, gate_internal, gate_external, main_clock_status,
        cpu_clock_run};
    wire logic [7:0] mode_view = {4'h0, halt_mode, stop_mode, cpu_clock_run, main_clock_status};

    ccs_clock_switch ccs_clock_switch_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .main_osc_ready(main_osc_ready), .internal_osc_ready(internal_osc_ready),
        .halt_exec(halt_exec), .stop_exec(stop_exec), .wake_event(wake_event),
        .osc_cfg(osc_cfg), .main_osc_enable(main_osc_enable),
        .internal_osc_enable(internal_osc_enable), .gate_internal(gate_internal),
        .gate_external(gate_external), .main_clock_status(main_clock_status),
        .cpu_clock_run(cpu_clock_run), .halt_mode(halt_mode), .stop_mode(stop_mode));

    ccs_osc_model ccs_osc_model_inst (.clk(clk), .main_en(main_osc_enable),
        .int_en(internal_osc_enable), .main_ready(main_osc_ready),
        .int_ready(internal_osc_ready));

    initial begin
        forever #50 clk = ~clk;
    end

    // ================================================================
    // Checking
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        rd_pend <= reg_rd;
    end

    // Read data stand for one cycle only, so they are taken mid-cycle.
    always @(negedge clk) begin
        if (rd_pend) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("unexpected read data %h with nothing expected", reg_rdata);
            end else begin
                chk("reg_rdata", reg_rdata, exp_q.pop_front());
            end
        end
        if (!reset) begin
            chk("gate overlap", {7'h00, gate_internal & gate_external}, 8'h00);
        end
    end

    // ================================================================
    // Register port and event tasks
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task settle;
        repeat (2) @(negedge clk);
    endtask

    task pulse(input logic [2:0] p);
        @(posedge clk);
        {halt_exec, stop_exec, wake_event} <= p;
        @(posedge clk);
        {halt_exec, stop_exec, wake_event} <= 3'b000;
        settle();
    endtask

    task wait_sig(input int s);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (watch[s] === 1'b1) break;
        end
        if (watch[s] !== 1'b1) begin
            n_errors++;
            $display("unexpected timeout on watch bit %0d: expected 1 seen %b", s, watch[s]);
        end
    endtask

    // ================================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk("clock after reset", clk_view, 8'h09);
        repeat (12) @(posedge clk);
        rd(CCS_ADDR_OSC_MODE, 8'h00);
        rd(CCS_ADDR_MAIN_OSC_CTL, 8'h80);
        rd(CCS_ADDR_MAIN_CLK_MODE, 8'h00);
        rd(CCS_ADDR_INT_OSC_MODE, 8'h80);
        rd(CCS_ADDR_STAB_STATUS, 8'h00);
        repeat (4) begin
            ra = 8'($random(seed)) | 8'h08;
            wr(ra, 8'($random(seed)));
            rd(ra, 8'h00);
        end
        $display("reset and map test done");
        wr(CCS_ADDR_OSC_MODE, 8'h41);
        settle();
        chk("osc_cfg", {5'h00, osc_cfg}, 8'h03);
        wr(CCS_ADDR_MAIN_OSC_CTL, 8'h00);
        settle();
        chk("main_osc_enable", {7'h00, main_osc_enable}, 8'h01);
        wait_sig(2);
        repeat (4) @(posedge clk);
        rd(CCS_ADDR_STAB_STATUS, 8'h01);
        wr(CCS_ADDR_MAIN_CLK_MODE, 8'h04);
        rd(CCS_ADDR_MAIN_CLK_MODE, 8'h04);
        wr(CCS_ADDR_MAIN_CLK_MODE, 8'h05);
        wait_sig(1);
        chk("clock on crystal", clk_view, 8'h07);
        rd(CCS_ADDR_MAIN_CLK_MODE, 8'h07);
        wr(CCS_ADDR_OSC_MODE, 8'h40);
        rd(CCS_ADDR_OSC_MODE, 8'h41);
        wr(CCS_ADDR_MAIN_CLK_MODE, 8'h01);
        rd(CCS_ADDR_MAIN_CLK_MODE, 8'h07);
        $display("switch to crystal test done");
        pulse(3'b100);
        chk("halt mode", mode_view, 8'h09);
        pulse(3'b001);
        chk("halt wake", mode_view, 8'h03);
        pulse(3'b010);
        chk("stop mode", mode_view, 8'h05);
        chk("stop enables", {6'h00, main_osc_enable, internal_osc_enable}, 8'h00);
        pulse(3'b001);
        chk("stop wake", mode_view, 8'h03);
        pulse(3'b110);
        chk("stop over halt", mode_view, 8'h05);
        pulse(3'b001);
        $display("standby test done");
        wait_sig(3);
        repeat (4) @(posedge clk);
        rd(CCS_ADDR_INT_OSC_MODE, 8'h80);
        wr(CCS_ADDR_MAIN_CLK_MODE, 8'h04);
        wait_sig(0);
        chk("clock back internal", clk_view, 8'h09);
        rd(CCS_ADDR_MAIN_CLK_MODE, 8'h04);
        wr(CCS_ADDR_MAIN_OSC_CTL, 8'h80);
        settle();
        chk("main_osc_enable", {7'h00, main_osc_enable}, 8'h00);
        $display("return to internal test done");
        repeat (4) @(posedge clk);
        // An external clock needs no settling, so the switch must not wait for ready.
        wr(CCS_ADDR_OSC_MODE, 8'hc0);
        wr(CCS_ADDR_MAIN_OSC_CTL, 8'h00);
        wr(CCS_ADDR_MAIN_CLK_MODE, 8'h05);
        wait_sig(1);
        chk("clock on external input", clk_view, 8'h07);
        chk("osc_cfg", {5'h00, osc_cfg}, 8'h07);
        rd(CCS_ADDR_STAB_STATUS, 8'h00);
        wr(CCS_ADDR_INT_OSC_MODE, 8'h01);
        settle();
        chk("internal_osc_enable", {7'h00, internal_osc_enable}, 8'h00);
        // Reset in mid-run, while the CPU is on the external input.
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk("clock after second reset", clk_view, 8'h09);
        rd(CCS_ADDR_OSC_MODE, 8'h00);
        wr(CCS_ADDR_OSC_MODE, 8'h01);
        rd(CCS_ADDR_OSC_MODE, 8'h01);
        $display("external input and reset test done");
        repeat (4) @(posedge clk);
        end_of_test();
    end

    // A hang in any wait ends the run here with a mismatch.
    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end
endmodule

// ==== tb/ccs_osc_model.sv ====
// Purpose: Behavioural main and internal oscillators beside the clock switch.
// Assumes: Ready levels are driven on the bench clock, seen async by the design.
// Notes: SETTLE counts cycles from enable to a settled ready level.
`timescale 1ns/1ps
module ccs_osc_model #(
    parameter int SETTLE = 6
) (
    input wire logic clk,
    input wire logic main_en,
    input wire logic int_en,
    output logic main_ready,
    output logic int_ready
);
    int main_cnt = 0;
    int int_cnt = 0;
    // ================================================================
    // Settling
    // A crystal is not ready the moment it is enabled; ready drops at once on stop.
    always @(posedge clk) begin
        main_cnt <= main_en ? main_cnt + 1 : 0;
        int_cnt <= int_en ? int_cnt + 1 : 0;
    end
    assign main_ready = main_cnt >= SETTLE;
    assign int_ready = int_cnt >= SETTLE;
endmodule
